// >>> hdl/temp_scanner_params.svh
// constants for the eight-channel temperature scanner
// Notes on behaviour
// - channel count is one plus the sum of jumper weights one, two, four.
// - all three count jumpers are fitted at delivery, giving eight channels.
// - exactly one channel's data goes to the controller per scan, then advance.
// - after the last selected channel, presentation resumes at channel 0.
// - unselected channels are skipped; N channels refresh within N scans.
// - each input is converted to 12 bits continuously, scan independent.
// - conversion of any one channel finishes within 35 microseconds.
// - the device appears as a 16-point input: two 8-bit image bytes.
// - the image carries the presented channel's indication and its value.
// - low eight data bits in first byte, upper four bits in second.
// - value is unsigned binary, 0 through 4095, proportional to input.
`ifndef TEMP_SCANNER_PARAMS_SVH
`define TEMP_SCANNER_PARAMS_SVH

`define CLK_FREQ_MHZ      200
`define CONV_MAX_NS       35000
`define CONV_CYCLES       ((`CONV_MAX_NS * `CLK_FREQ_MHZ) / 1000)
`define SAR_STEP_CYCLES   8'h20
`define CODE_BITS         12
`define NUM_CHANNELS      8
`define JUMPER_DEFAULT    3'h7
`define CHAN_FIRST        3'h0
`define LOW_BYTE_LSB      0
`define HIGH_BITS_LSB     8
`define INDEX_POS_LSB     4
`define ADDR_CTRL         12'h000
`define ADDR_JUMPER       12'h004
`define ADDR_IMAGE        12'h008
`define ADDR_STATUS       12'h00c
`define ADDR_RESULT0      12'h010
`define CTRL_RESET        32'h0000_0001

`endif

// >>> hdl/temp_scanner_pkg.sv
// types shared by the temperature scanner files
package temp_scanner_pkg;
  typedef logic [11:0] code_t;
  typedef logic [2:0]  chan_t;
  typedef enum logic [1:0] {CONV_IDLE, CONV_START, CONV_BUSY} conv_state_t;
endpackage : temp_scanner_pkg

// >>> hdl/sar_converter.sv
// successive approximation converter sequencing all eight inputs
`timescale 1ns/1ps
`include "temp_scanner_params.svh"
module sar_converter
  import temp_scanner_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // comparator front end
  input  wire logic       cmpAbove,
  output logic [11:0]     trialCode,
  output logic [2:0]      muxSel,
  // finished conversion
  output logic            resValid,
  output logic [2:0]      resChan,
  output logic [11:0]     resCode
);
  typedef struct packed {
    conv_state_t st;
    chan_t       chan;
    code_t       trial;
    logic [3:0]  bitIdx;
    logic [7:0]  step;
    logic [15:0] age;
    logic        valid;
    code_t       code;
    chan_t       doneChan;
  } sar_state_t;

  sar_state_t s_q, s_d;

  // one trial bit per settle period; twelve bits fit the limit with room
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.age = s_q.age + 16'h0001;
    unique case (s_q.st)
      CONV_IDLE: begin
        s_d.st = CONV_START;
      end
      CONV_START: begin
        s_d.trial = 12'h800;
        s_d.bitIdx = 4'hb;
        s_d.step = 8'h00;
        s_d.age = 16'h0000;
        s_d.st = CONV_BUSY;
      end
      CONV_BUSY: begin
        if (s_q.step == `SAR_STEP_CYCLES) begin
          s_d.step = 8'h00;
          if (!cmpAbove)
            s_d.trial[s_q.bitIdx] = 1'b0;
          if (s_q.bitIdx == 4'h0) begin
            s_d.valid = 1'b1;
            s_d.code = cmpAbove ? s_q.trial : (s_q.trial & ~12'h001);
            s_d.doneChan = s_q.chan; // name the input just converted
            s_d.chan = s_q.chan + 3'h1; // free-running, all inputs
            s_d.st = CONV_START;
          end else begin
            s_d.trial[s_q.bitIdx - 4'h1] = 1'b1;
            s_d.bitIdx = s_q.bitIdx - 4'h1;
          end
        end else begin
          s_d.step = s_q.step + 8'h01;
        end
      end
      default: s_d.st = CONV_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trialCode = s_q.trial;
  assign muxSel    = s_q.chan;
  assign resValid  = s_q.valid;
  assign resChan   = s_q.doneChan;
  assign resCode   = s_q.code;

  property p_conv_time;
    @(posedge clk) disable iff (!arst_n)
      (s_q.st == CONV_START) |-> ##[1:420] s_d.valid;
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("conversion exceeded limit");

  property p_conv_bound;
    @(posedge clk) disable iff (!arst_n)
      s_q.age <= 16'(`CONV_CYCLES);
  endproperty
  a_conv_bound: assert property (p_conv_bound)
    else $error("conversion age past 35 us");
endmodule : sar_converter

// >>> hdl/image_buffer.sv
// two-entry buffer for presented image words
`timescale 1ns/1ps
`include "temp_scanner_params.svh"
module image_buffer
  import temp_scanner_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // fill side
  input  wire logic        inValid,
  output logic             inReady,
  input  wire logic [15:0] inWord,
  // drain side
  output logic             outValid,
  input  wire logic        outReady,
  output logic [15:0]      outWord
);
  typedef struct packed {
    logic [1:0][15:0] mem;
    logic             wrPtr;
    logic             rdPtr;
    logic [1:0]       count;
  } buf_state_t;

  buf_state_t b_q, b_d;
  logic push;
  logic pop;

  // full blocks the filler, so a stalled reader loses nothing
  always_comb begin
    b_d = b_q;
    push = inValid && (b_q.count != 2'h2);
    pop = (b_q.count != 2'h0) && outReady;
    if (push) begin
      b_d.mem[b_q.wrPtr] = inWord;
      b_d.wrPtr = ~b_q.wrPtr;
    end
    if (pop)
      b_d.rdPtr = ~b_q.rdPtr;
    b_d.count = b_q.count + {1'b0, push} - {1'b0, pop};
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  assign inReady  = (b_q.count != 2'h2);
  assign outValid = (b_q.count != 2'h0);
  assign outWord  = b_q.mem[b_q.rdPtr];
endmodule : image_buffer

// >>> hdl/temp_scanner.sv
// eight-channel temperature scanner with apb access and scan image
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "temp_scanner_params.svh"
module temp_scanner
  import temp_scanner_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // controller scan port
  input  wire logic        scanStrobe,
  output logic             imageValid,
  input  wire logic        imageReady,
  output logic [7:0]       lowDataImageByte,
  output logic [7:0]       highDataImageByte,
  // converter front end
  input  wire logic        cmpAbove,
  output logic [11:0]      trialCode,
  output logic [2:0]       muxSel
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]       jumpers;
    logic             scanRun;
    chan_t            nextChan;
    chan_t            shownChan;
    logic [7:0][11:0] result;
    logic [7:0]       fresh;
    logic [31:0]      rdata;
    logic [15:0]      scanCount;
  } top_state_t;

  top_state_t t_q, t_d;
  logic        resValid;
  logic [2:0]  resChan;
  logic [11:0] resCode;
  logic        bufReady;
  logic        pushWord;
  logic [15:0] pushImage;
  logic [15:0] outWord;
  logic        apbWr;
  logic        apbRd;

  // last channel index for the jumper setting
  function automatic chan_t last_chan(input logic [2:0] j);
    last_chan = j; // count is 1 + 4a + 2b + c, index is that minus one
  endfunction : last_chan

  // pack channel index and code into the 16-point image
  function automatic logic [15:0] pack_image(input chan_t c,
                                             input code_t v);
    logic [15:0] w;
    w = 16'h0000;
    w[`HIGH_BITS_LSB +: 8] = {1'b0, c, v[11:8]};
    w[`LOW_BYTE_LSB +: 8] = v[7:0];
    pack_image = w;
  endfunction : pack_image

  // result window: one word per channel from the first result offset;
  // subtracting the base keeps the decode right for any base address
  function automatic logic is_result_addr(input logic [11:0] a);
    logic [11:0] off;
    off = a - `ADDR_RESULT0;
    is_result_addr = (off[11:5] == 7'h00) && (off[1:0] == 2'h0);
  endfunction : is_result_addr

  // channel slot addressed inside the result window
  function automatic chan_t result_slot(input logic [11:0] a);
    logic [11:0] off;
    off = a - `ADDR_RESULT0;
    result_slot = off[4:2];
  endfunction : result_slot

  // ------------------------------------------------------------
  // converter and output buffer
  // ------------------------------------------------------------
  sar_converter u_conv (
    .clk      (clk),
    .arst_n   (arst_n),
    .cmpAbove (cmpAbove),
    .trialCode(trialCode),
    .muxSel   (muxSel),
    .resValid (resValid),
    .resChan  (resChan),
    .resCode  (resCode)
  );

  image_buffer u_buf (
    .clk     (clk),
    .arst_n  (arst_n),
    .inValid (pushWord),
    .inReady (bufReady),
    .inWord  (pushImage),
    .outValid(imageValid),
    .outReady(imageReady),
    .outWord (outWord)
  );

  // ------------------------------------------------------------
  // scan sequencing and register file
  // ------------------------------------------------------------
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;
  // a scan is only taken while the buffer has room, never dropped
  assign pushWord = scanStrobe && t_q.scanRun && bufReady;
  assign pushImage = pack_image(t_q.nextChan, t_q.result[t_q.nextChan]);

  // next state: results, scan sequencing, register writes and reads
  always_comb begin
    t_d = t_q;
    if (resValid) begin
      t_d.result[resChan] = resCode; // latest value kept
      t_d.fresh[resChan] = 1'b1;
    end
    if (pushWord) begin
      // one channel per scan, whole word at once
      t_d.shownChan = t_q.nextChan;
      t_d.scanCount = t_q.scanCount + 16'h0001;
      if (t_q.nextChan >= last_chan(t_q.jumpers))
        t_d.nextChan = `CHAN_FIRST; // wrap, skip unused
      else
        t_d.nextChan = t_q.nextChan + 3'h1;
      if (!(resValid && resChan == t_q.nextChan))
        t_d.fresh[t_q.nextChan] = 1'b0;
    end
    if (apbWr) begin
      unique case (paddr)
        `ADDR_CTRL: begin
          t_d.scanRun = pwdata[0];
          if ((pwdata & `CTRL_RESET) != 32'h0 && pwdata[1])
            t_d.nextChan = `CHAN_FIRST;
        end
        `ADDR_JUMPER: begin
          t_d.jumpers = pwdata[2:0];
          t_d.nextChan = `CHAN_FIRST;
        end
        default: ;
      endcase
    end
    if (apbRd) begin
      if (is_result_addr(paddr))
        t_d.rdata = {20'h0, t_q.result[result_slot(paddr)]};
      else
        unique case (paddr)
          `ADDR_CTRL:   t_d.rdata = {31'h0, t_q.scanRun};
          `ADDR_JUMPER: t_d.rdata = {29'h0, t_q.jumpers};
          `ADDR_IMAGE:  t_d.rdata = {16'h0, outWord};
          `ADDR_STATUS: t_d.rdata = {t_q.scanCount, t_q.fresh,
                                     5'h0, t_q.shownChan};
          default:      t_d.rdata = 32'h0;
        endcase
    end
  end

  // state register; jumpers come up all fitted, eight channels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t_q <= '0;
      t_q.jumpers <= `JUMPER_DEFAULT;
      t_q.scanRun <= 1'b1;
    end else begin
      t_q <= t_d;
    end
  end

  // image bytes come straight from the buffer's flip-flops
  assign lowDataImageByte  = outWord[`LOW_BYTE_LSB +: 8];
  assign highDataImageByte = outWord[`HIGH_BITS_LSB +: 8];

  // zero-wait apb: data registered in setup, answered in access
  assign pready  = 1'b1;
  assign prdata  = t_q.rdata;
  assign pslverr = 1'b0;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_advance;
    @(posedge clk) disable iff (!arst_n)
      pushWord && t_q.nextChan < last_chan(t_q.jumpers) && !apbWr
        |=> t_q.nextChan == $past(t_q.nextChan) + 3'h1;
  endproperty
  a_advance: assert property (p_advance)
    else $error("channel did not advance");

  property p_wrap;
    @(posedge clk) disable iff (!arst_n)
      pushWord && t_q.nextChan >= last_chan(t_q.jumpers)
        |=> t_q.nextChan == `CHAN_FIRST;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("no wrap to first channel");

  property p_skip;
    @(posedge clk) disable iff (!arst_n)
      t_q.scanRun |-> t_q.nextChan <= t_q.jumpers || t_q.nextChan == 3'h0;
  endproperty
  a_skip: assert property (p_skip)
    else $error("unselected channel reached");

  property p_pair;
    @(posedge clk) disable iff (!arst_n)
      pushWord |-> pushImage[11:0] ==
        {t_q.result[t_q.nextChan][11:8], t_q.result[t_q.nextChan][7:0]}
        && pushImage[14:12] == t_q.nextChan;
  endproperty
  a_pair: assert property (p_pair)
    else $error("index and data mismatched");

  property p_keep;
    @(posedge clk) disable iff (!arst_n)
      resValid |=> t_q.result[$past(resChan)] == $past(resCode);
  endproperty
  a_keep: assert property (p_keep)
    else $error("result not kept");

  property p_default;
    @(posedge clk) $rose(arst_n) |-> t_q.jumpers == 3'h7;
  endproperty
  a_default: assert property (p_default)
    else $error("default not eight channels");

  property p_top;
    @(posedge clk) disable iff (!arst_n)
      highDataImageByte[7] == 1'b0;
  endproperty
  a_top: assert property (p_top)
    else $error("spare image bit set");

  property p_one_per_scan;
    @(posedge clk) disable iff (!arst_n)
      pushWord |-> t_q.scanCount + 16'h0001 == t_d.scanCount;
  endproperty
  a_one_per_scan: assert property (p_one_per_scan)
    else $error("scan count slip");

  // ------------------------------------------------------------
  // handshake and register checks
  // ------------------------------------------------------------
  // a scan taken into an empty buffer is on the pins one cycle on
  sequence s_push_into_empty;
    pushWord && !imageValid;
  endsequence

  sequence s_word_shown;
    imageValid && {highDataImageByte, lowDataImageByte} == $past(pushImage);
  endsequence

  property p_show;
    @(posedge clk) disable iff (!arst_n)
      s_push_into_empty |=> s_word_shown;
  endproperty
  a_show: assert property (p_show)
    else $error("pushed word not shown");

  // a stalled controller sees the same word until it takes it
  sequence s_stalled;
    imageValid && !imageReady;
  endsequence

  property p_hold;
    @(posedge clk) disable iff (!arst_n)
      s_stalled |=> imageValid && $stable(outWord);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled image word changed");

  // a strobe refused by a full buffer must not skip a channel
  sequence s_refused;
    scanStrobe && t_q.scanRun && !bufReady && !apbWr;
  endsequence

  property p_refuse;
    @(posedge clk) disable iff (!arst_n)
      s_refused |=> $stable(t_q.nextChan) && $stable(t_q.scanCount);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused scan advanced channel");

  property p_count_hold;
    @(posedge clk) disable iff (!arst_n)
      !pushWord |=> $stable(t_q.scanCount);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("scan count moved without a scan");

  // jumper writes take effect at once and restart at channel 0
  sequence s_jumper_write;
    apbWr && paddr == `ADDR_JUMPER;
  endsequence

  property p_jumper;
    @(posedge clk) disable iff (!arst_n)
      s_jumper_write |=> t_q.jumpers == $past(pwdata[2:0])
        && t_q.nextChan == `CHAN_FIRST;
  endproperty
  a_jumper: assert property (p_jumper)
    else $error("jumper write not applied");

  property p_ctrl;
    @(posedge clk) disable iff (!arst_n)
      apbWr && paddr == `ADDR_CTRL |=> t_q.scanRun == $past(pwdata[0]);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("scan enable write not applied");

  property p_restart;
    @(posedge clk) disable iff (!arst_n)
      apbWr && paddr == `ADDR_CTRL && pwdata[1:0] == 2'h3
        |=> t_q.nextChan == `CHAN_FIRST;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not return to first channel");

  property p_fresh;
    @(posedge clk) disable iff (!arst_n)
      resValid |=> t_q.fresh[$past(resChan)];
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("fresh flag not set by new result");

  property p_read_result;
    @(posedge clk) disable iff (!arst_n)
      apbRd && is_result_addr(paddr)
        |=> prdata == {20'h0, $past(t_q.result[result_slot(paddr)])};
  endproperty
  a_read_result: assert property (p_read_result)
    else $error("result read returned wrong word");

  property p_status_read;
    @(posedge clk) disable iff (!arst_n)
      apbRd && paddr == `ADDR_STATUS
        |=> prdata[31:16] == $past(t_q.scanCount);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read lost the scan count");
endmodule : temp_scanner

// >>> bench/scan_controller.sv
// controller model: scan boundary pulses and image word acceptance
`timescale 1ns/1ps
module scan_controller (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // bench control
  input  wire logic scanRun,
  input  wire logic stall,
  // scan port
  output logic      scanStrobe,
  output logic      imageReady
);
  logic [1:0] scanDiv_q;

  // ------------------------------------------------------------
  // scan timing
  // ------------------------------------------------------------
  // one single-cycle scan boundary every four cycles while running
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scanDiv_q  <= 2'h0;
      scanStrobe <= 1'b0;
      imageReady <= 1'b0;
    end else begin
      scanDiv_q  <= scanDiv_q + 2'h1;
      scanStrobe <= scanRun && (scanDiv_q == 2'h0);
      imageReady <= !stall; // a slow controller just stops taking words
    end
  end
endmodule : scan_controller

// >>> bench/testbench.sv
// self-checking bench for the eight-channel temperature scanner
`timescale 1ns/1ps
`include "temp_scanner_params.svh"
`define CHECK_EQ(got, exp) begin numChecks++; if ((got) !== (exp)) begin \
  miscompares++; $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); \
  end end
module testbench
  import temp_scanner_pkg::*;
;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, trialCode;
  logic [31:0] pwdata, prdata, rd, rng;
  logic        scanStrobe, imageValid, imageReady, cmpAbove, scanRun, stall;
  logic [7:0]  lowDataImageByte, highDataImageByte;
  logic [2:0]  muxSel;
  logic [15:0] expWord;
  logic [15:0] expQ [$];
  code_t       analogVal [8];
  chan_t       nextCh, lastCh, lastPushed;
  logic        scanOn;
  int          occ, strobeCnt, miscompares, numChecks, j, k, pushCnt;

  temp_scanner i_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scanStrobe(scanStrobe), .imageValid(imageValid),
    .imageReady(imageReady), .lowDataImageByte(lowDataImageByte),
    .highDataImageByte(highDataImageByte), .cmpAbove(cmpAbove),
    .trialCode(trialCode), .muxSel(muxSel));
  scan_controller i_ctrl (.clk(clk), .arst_n(arst_n), .scanRun(scanRun),
    .stall(stall), .scanStrobe(scanStrobe), .imageReady(imageReady));

  // ------------------------------------------------------------
  // clock and analog front end
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ideal comparator on the selected input
  assign cmpAbove = (analogVal[muxSel] >= trialCode);

  // ------------------------------------------------------------
  // prediction and checking of image words
  // ------------------------------------------------------------
  // strobes seen while two words wait are refused and do not advance
  always @(posedge clk) begin
    if (scanStrobe && arst_n) begin
      strobeCnt++;
      if (occ < 2 && scanOn) begin
        expQ.push_back({1'b0, nextCh, analogVal[nextCh]});
        occ++;
        pushCnt++;
        lastPushed = nextCh;
        nextCh = (nextCh == lastCh) ? 3'h0 : nextCh + 3'h1;
      end
    end
    if (imageValid && imageReady) begin
      occ--;
      expWord = (expQ.size() != 0) ? expQ.pop_front() : 16'hxxxx;
      `CHECK_EQ(highDataImageByte, expWord[15:8])
      `CHECK_EQ(lowDataImageByte, expWord[7:0])
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic endOfTest();
    if (miscompares == 0 && numChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : endOfTest

  task automatic timeoutHit();
    miscompares++;
    endOfTest();
  endtask : timeoutHit

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xorshift

  // fresh input levels; conversion is given time before any scan
  task automatic newInputs();
    logic [31:0] v;
    for (int c = 0; c < 8; c++) begin
      v = xorshift();
      analogVal[c] <= v[11:0];
    end
  endtask : newInputs

  // one apb transfer, entered right after a rising edge
  task automatic apbXfer(input logic wr, input logic [11:0] a,
                         input logic [31:0] d, output logic [31:0] r);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timeoutHit();
    r = prdata;
    `CHECK_EQ(pslverr, 1'b0)
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk); // one idle edge, so no signal is set twice at once
  endtask : apbXfer

  // run n controller scans, optionally stalled, then drain the buffer
  task automatic runScans(input int n, input logic st);
    int i;
    int t;
    stall   <= st;
    scanRun <= 1'b1;
    t = strobeCnt + n;
    for (i = 0; i < 1000 && strobeCnt < t; i++) @(posedge clk);
    if (i == 1000) timeoutHit();
    scanRun <= 1'b0;
    if (st) begin
      `CHECK_EQ(imageValid, 1'b1)
      apbXfer(1'b0, `ADDR_IMAGE, 32'h0, rd);
      `CHECK_EQ(rd[15:0], expQ[0])
    end
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = 0; i < 200 && (expQ.size() != 0 || imageValid); i++)
      @(posedge clk);
    if (i == 200) timeoutHit();
    `CHECK_EQ(imageValid, 1'b0)
  endtask : runScans

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, scanRun, stall} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    numChecks = 0;
    occ = 0;
    strobeCnt = 0;
    pushCnt = 0;
    scanOn = 1'b1;
    nextCh = 3'h0;
    lastCh = 3'h7;
    rng = 32'h5f67;
    newInputs();
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apbXfer(1'b0, `ADDR_JUMPER, 32'h0, rd);
    `CHECK_EQ(rd[2:0], `JUMPER_DEFAULT)
    apbXfer(1'b0, 12'h030, 32'h0, rd); // unmapped word reads zero
    `CHECK_EQ(rd, 32'h0000_0000)
    repeat (8000) @(posedge clk);
    runScans(10, 1'b0); // all eight then wrap
    runScans(5, 1'b1);  // full buffer refuses strobes
    // status holds every taken scan and the last channel pushed
    apbXfer(1'b0, `ADDR_STATUS, 32'h0, rd);
    `CHECK_EQ(rd[31:16], pushCnt[15:0])
    `CHECK_EQ(rd[2:0], lastPushed)
    // scans are ignored while disabled; enable with restart at channel 0
    apbXfer(1'b1, `ADDR_CTRL, 32'h0000_0000, rd);
    scanOn = 1'b0;
    runScans(4, 1'b0);
    apbXfer(1'b0, `ADDR_CTRL, 32'h0, rd);
    `CHECK_EQ(rd, 32'h0000_0000)
    apbXfer(1'b1, `ADDR_CTRL, 32'h0000_0003, rd);
    scanOn = 1'b1;
    nextCh = 3'h0;
    runScans(3, 1'b0); // restart shows channels 0, 1, 2
    // every jumper setting, with new inputs each time
    for (j = 0; j < 8; j++) begin
      newInputs();
      apbXfer(1'b1, `ADDR_JUMPER, {29'h0, 3'(j)}, rd);
      nextCh = 3'h0;
      lastCh = 3'(j);
      repeat (8000) @(posedge clk);
      for (k = 0; k <= j; k++) begin
        apbXfer(1'b0, `ADDR_RESULT0 + 12'(4 * k), 32'h0, rd);
        `CHECK_EQ(rd[11:0], analogVal[k])
      end
      runScans(j + 3, 1'b0);
    end
    endOfTest();
  end
endmodule : testbench
